// ==== verilog/su1_pkg.sv ====
/*
 Constants shared by the serial port one block: register indices and byte
 addresses, control and status bit positions, reset values, mode codes,
 bit timing and frame lengths.
 Assumes a 200 MHz system clock and a 12-bit APB byte address.
*/
`default_nettype none
package su1_pkg;
   // ==========================================================
   // Register map (index; byte address is four times the index)
   localparam int          SU1_AW        = 12;
   localparam logic [7:0]  SU1_IDX_CTRL  = 8'hC0;
   localparam logic [7:0]  SU1_IDX_BUF   = 8'hC1;
   localparam logic [7:0]  SU1_IDX_CFG   = 8'hC2;
   localparam logic [7:0]  SU1_IDX_T2RL  = 8'hC3;
   localparam logic [7:0]  SU1_IDX_IST   = 8'hC4;
   localparam logic [7:0]  SU1_IDX_ICLR  = 8'hC5;
   localparam logic [7:0]  SU1_IDX_IEN   = 8'hC6;

   function automatic logic [SU1_AW-1:0] su1_addr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

   // ==========================================================
   // Field positions
   localparam int SU1_B_SM0  = 7;
   localparam int SU1_B_SM1  = 6;
   localparam int SU1_B_MP   = 5;
   localparam int SU1_B_REN  = 4;
   localparam int SU1_B_TB8  = 3;
   localparam int SU1_B_RB8  = 2;
   localparam int SU1_B_TI   = 1;
   localparam int SU1_B_RI   = 0;
   localparam int SU1_C_DBL  = 0;
   localparam int SU1_C_PRIO = 1;
   localparam int SU1_C_T2   = 2;
   localparam int SU1_I_TX   = 0;
   localparam int SU1_I_RX   = 1;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  SU1_CTRL_RST = 8'h00;
   localparam logic [7:0]  SU1_BUF_RST  = 8'h00;
   localparam logic [2:0]  SU1_CFG_RST  = 3'h0;
   localparam logic [15:0] SU1_T2RL_RST = 16'h0000;
   localparam logic [1:0]  SU1_IEN_RST  = 2'h0;

   // ==========================================================
   // Modes and timing
   localparam logic [1:0] SU1_MODE0 = 2'h0;
   localparam logic [1:0] SU1_MODE1 = 2'h1;
   localparam logic [1:0] SU1_MODE2 = 2'h2;
   localparam int SU1_M0_BIT_SLOW = 12;
   localparam int SU1_M0_BIT_FAST = 4;
   localparam int SU1_M2_BIT      = 64;
   localparam int SU1_M2_BIT_DBL  = 32;
   localparam int SU1_OVS         = 16;
   localparam int SU1_T2_PRE      = 2;
   localparam logic [5:0] SU1_M0_HALF_SLOW = 6'(SU1_M0_BIT_SLOW / 2);
   localparam logic [5:0] SU1_M0_HALF_FAST = 6'(SU1_M0_BIT_FAST / 2);
   localparam logic [5:0] SU1_M2_DIV     = 6'(SU1_M2_BIT / SU1_OVS);
   localparam logic [5:0] SU1_M2_DIV_DBL = 6'(SU1_M2_BIT_DBL / SU1_OVS);
   localparam logic [3:0] SU1_OVS_MID  = 4'(SU1_OVS / 2 - 1);
   localparam logic [3:0] SU1_OVS_LAST = 4'(SU1_OVS - 1);

   // ==========================================================
   // Frame lengths in bits
   localparam logic [3:0] SU1_M0_BITS = 4'h8;
   localparam logic [3:0] SU1_A8_BITS = 4'hA;
   localparam logic [3:0] SU1_A9_BITS = 4'hB;
   localparam logic [3:0] SU1_RX_BITS = 4'h9;
   localparam logic [3:0] SU1_M0_END  = 4'h1;
   localparam logic [3:0] SU1_ASY_END = 4'h2;
endpackage
`default_nettype wire

// ==== verilog/su1_rate.sv ====
/*
 Bit rate generator: half-bit ticks for synchronous mode, 16x sample
 ticks for the asynchronous modes, and the timer 2 baud generator.
 Assumes idle and timer1_ovf come from logic on clk_sys.
*/
`default_nettype none
module su1_rate import su1_pkg::*; (
   input  wire logic        clk_sys,    // System clock
   input  wire logic        rstn,       // Sync reset, low
   input  wire logic        idle,       // Core idle
   input  wire logic [1:0]  mode,       // Port mode
   input  wire logic        multiproc,  // Multiprocessor bit
   input  wire logic        doubler,    // Baud doubler
   input  wire logic        t2_sel,     // Timer 2 paces modes 1, 3
   input  wire logic        timer1_ovf, // Timer 1 overflow pulse
   input  wire logic [15:0] t2_reload,  // Timer 2 reload value
   output logic             m0_half,    // Half-bit tick, mode 0
   output logic             tick16      // Sample tick, async
);
   typedef struct packed {
      logic [5:0]  div;
      logic        t2_pre;
      logic [15:0] t2_cnt;
      logic        m0_half;
      logic        tick16;
   } su1_rate_t;

   su1_rate_t r;
   su1_rate_t next_r;
   logic [5:0] lim;
   logic       t2_ovf;

   // ==========================================================
   // Divider
   always_comb begin
      next_r = r;
      next_r.m0_half = 1'b0;
      next_r.tick16 = 1'b0;
      t2_ovf = 1'b0;
      next_r.t2_pre = ~r.t2_pre;
      if (r.t2_pre == 1'(SU1_T2_PRE - 1)) begin
         if (r.t2_cnt == 16'hFFFF) begin
            next_r.t2_cnt = t2_reload;
            t2_ovf = 1'b1;
         end else begin
            next_r.t2_cnt = r.t2_cnt + 16'h0001;
         end
      end
      if (mode == SU1_MODE0) begin
         lim = multiproc ? SU1_M0_HALF_FAST : SU1_M0_HALF_SLOW;
      end else begin
         lim = doubler ? SU1_M2_DIV_DBL : SU1_M2_DIV;
      end
      // Fixed rates stop while the core idles
      if (!idle) begin
         if (r.div >= lim - 6'h01) begin
            next_r.div = 6'h00;
            next_r.m0_half = (mode == SU1_MODE0);
            next_r.tick16 = (mode == SU1_MODE2);
         end else begin
            next_r.div = r.div + 6'h01;
         end
      end
      if (mode[0]) begin
         next_r.tick16 = t2_sel ? t2_ovf : timer1_ovf;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign m0_half = r.m0_half;
   assign tick16 = r.tick16;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_m0_slow_period: assert property (
      (m0_half && mode == SU1_MODE0 && !multiproc) |=> (!m0_half) [*5]
   ) else $error("mode 0 half bit shorter than six clocks");
   chk_m2_period: assert property (
      (tick16 && mode == SU1_MODE2 && !doubler) |=> (!tick16) [*3]
   ) else $error("mode 2 sample tick faster than four clocks");
   chk_idle_stop: assert property (
      (idle && !mode[0]) |=> (!m0_half && !tick16)
   ) else $error("fixed rate tick during idle");
   chk_t2_half_rate: assert property (
      $changed(r.t2_cnt) |=> $stable(r.t2_cnt)
   ) else $error("timer 2 advanced on two clocks in a row");
   chk_timer_pick: assert property (
      (mode[0] && !t2_sel && timer1_ovf) |=> tick16
   ) else $error("timer 1 overflow did not pace the port");
endmodule
`default_nettype wire

// ==== verilog/su1_uart.sv ====
/*
 Serial port one: synchronous shift mode and three asynchronous frame
 modes, APB register access, sticky interrupt status with enable.
 Assumes idle and timer1_ovf come from logic on clk_sys; rxd_i is a pin.
*/
// Added by the designer: the APB register port.
// Notes on behaviour
// - Async frames: one start bit, 8 or 9 data bits, one stop bit.
// - Mode 0 shifts 8 bits, bit period 12 clocks, 4 with multiproc.
// - Mode 1: 10-bit frame; 3: timer 11-bit; 2: 64 or 32 clocks.
// - Modes 1 and 3 paced by timer 1 or timer 2 overflow.
// - Fixed-rate pacing clock stops while the core is idle.
// - Receive enable gates reception; in mode 0 it starts one.
// - Modes 2 and 3 send the ninth transmit bit as ninth data bit.
// - Ninth received bit; stop bit in mode 1 without multiproc.
// - Transmit done at end of last data bit, eighth in mode 0.
// - Receive done after eighth bit, stop sample, or ninth sample.
// - Buffer address: writes go to transmit, reads from receive.
// - Priority bit marks this port's interrupt as high priority.
// - Timer 2 as baud generator advances once every 2 clocks.
`default_nettype none
module su1_uart import su1_pkg::*; (
   input  wire logic        clk_sys,    // System clock
   input  wire logic        rstn,       // Sync reset, low
   input  wire logic        psel,       // APB select
   input  wire logic        penable,    // APB enable
   input  wire logic        pwrite,     // APB write
   input  wire logic [11:0] paddr,      // APB byte address
   input  wire logic [31:0] pwdata,     // APB write data
   output logic      [31:0] prdata,     // APB read data
   output logic             pready,     // APB ready
   output logic             pslverr,    // APB error
   input  wire logic        idle,       // Core idle
   input  wire logic        timer1_ovf, // Timer 1 overflow pulse
   input  wire logic        rxd_i,      // Receive pin in
   output logic             rxd_o,      // Receive pin out, mode 0
   output logic             rxd_oe,     // Receive pin enable
   output logic             txd,        // Transmit pin
   output logic             irq,        // Interrupt level
   output logic             irq_prio    // High priority marker
);
   typedef enum logic [1:0] {
      SU1_TX_IDLE,
      SU1_TX_BUSY
   } su1_tx_t;

   typedef enum logic [1:0] {
      SU1_RX_IDLE,
      SU1_RX_START,
      SU1_RX_DATA,
      SU1_RX_SYNC
   } su1_rx_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  tx_buf;
      logic [7:0]  rx_buf;
      logic [2:0]  cfg;
      logic [15:0] t2_rl;
      logic [1:0]  ist;
      logic [1:0]  ien;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      su1_tx_t     tx_st;
      logic [10:0] tx_sh;
      logic [3:0]  tx_left;
      logic [3:0]  tx_sub;
      logic        tx_ph;
      su1_rx_t     rx_st;
      logic [8:0]  rx_sh;
      logic [3:0]  rx_left;
      logic [3:0]  rx_sub;
      logic        rx_ph;
      logic        rx_s1;
      logic        rx_s2;
      logic        rx_prev;
      logic        txd;
      logic        rxd_o;
      logic        rxd_oe;
      logic        irq;
      logic        irq_prio;
   } su1_state_t;

   su1_state_t r;
   su1_state_t next_r;
   logic [1:0] mode;
   logic       setup;
   logic       wr;
   logic       tx_start;
   logic       tx_ev;
   logic       rx_ev;
   logic       rx_fin;
   logic [8:0] rx_new;
   logic       m0_rx_go;
   logic       bit_end;
   logic       m0_half;
   logic       tick16;

   // ==========================================================
   // Bit rate
   su1_rate u_rate (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .idle       (idle),
      .mode       (r.ctrl[SU1_B_SM0:SU1_B_SM1]),
      .multiproc  (r.ctrl[SU1_B_MP]),
      .doubler    (r.cfg[SU1_C_DBL]),
      .t2_sel     (r.cfg[SU1_C_T2]),
      .timer1_ovf (timer1_ovf),
      .t2_reload  (r.t2_rl),
      .m0_half    (m0_half),
      .tick16     (tick16)
   );

   // ==========================================================
   // Next state
   always_comb begin
      next_r = r;
      mode = r.ctrl[SU1_B_SM0:SU1_B_SM1];
      setup = psel && !penable;
      wr = psel && penable && r.pready && pwrite;
      tx_start = 1'b0;
      tx_ev = 1'b0;
      rx_ev = 1'b0;
      rx_fin = 1'b0;
      rx_new = r.rx_sh;
      m0_rx_go = 1'b0;
      bit_end = 1'b0;

      // APB: answer in the first access cycle
      next_r.pready = setup;
      if (setup) begin
         next_r.prdata = 32'h0000_0000;
         next_r.pslverr = 1'b0;
         case (paddr)
            su1_addr(SU1_IDX_CTRL): next_r.prdata[7:0] = r.ctrl;
            su1_addr(SU1_IDX_BUF):  next_r.prdata[7:0] = r.rx_buf;
            su1_addr(SU1_IDX_CFG):  next_r.prdata[2:0] = r.cfg;
            su1_addr(SU1_IDX_T2RL): next_r.prdata[15:0] = r.t2_rl;
            su1_addr(SU1_IDX_IST):  next_r.prdata[1:0] = r.ist;
            su1_addr(SU1_IDX_ICLR): next_r.prdata[1:0] = 2'h0;
            su1_addr(SU1_IDX_IEN):  next_r.prdata[1:0] = r.ien;
            default:                next_r.pslverr = 1'b1;
         endcase
      end
      if (wr) begin
         case (paddr)
            su1_addr(SU1_IDX_CTRL): begin
               next_r.ctrl = pwdata[7:0];
               m0_rx_go = pwdata[SU1_B_REN] && !r.ctrl[SU1_B_REN]
                  && (pwdata[SU1_B_SM0:SU1_B_SM1] == SU1_MODE0)
                  && !pwdata[SU1_B_RI];
            end
            su1_addr(SU1_IDX_BUF): begin
               next_r.tx_buf = pwdata[7:0];
               tx_start = (r.tx_st == SU1_TX_IDLE);
            end
            su1_addr(SU1_IDX_CFG):  next_r.cfg = pwdata[2:0];
            su1_addr(SU1_IDX_T2RL): next_r.t2_rl = pwdata[15:0];
            su1_addr(SU1_IDX_ICLR): next_r.ist = r.ist & ~pwdata[1:0];
            su1_addr(SU1_IDX_IEN):  next_r.ien = pwdata[1:0];
            default: ;
         endcase
      end

      // Transmitter
      case (r.tx_st)
         SU1_TX_IDLE: begin
            if (tx_start) begin
               next_r.tx_st = SU1_TX_BUSY;
               next_r.tx_sub = 4'h0;
               next_r.tx_ph = 1'b0;
               case (mode)
                  SU1_MODE0: begin
                     next_r.tx_sh = {3'h7, pwdata[7:0]};
                     next_r.tx_left = SU1_M0_BITS;
                  end
                  SU1_MODE1: begin
                     next_r.tx_sh = {2'h3, pwdata[7:0], 1'b0};
                     next_r.tx_left = SU1_A8_BITS;
                  end
                  default: begin
                     next_r.tx_sh = {1'b1, r.ctrl[SU1_B_TB8], pwdata[7:0],
                                     1'b0};
                     next_r.tx_left = SU1_A9_BITS;
                  end
               endcase
            end
         end
         SU1_TX_BUSY: begin
            if (mode == SU1_MODE0) begin
               if (m0_half) begin
                  next_r.tx_ph = !r.tx_ph;
                  bit_end = r.tx_ph;
               end
            end else if (tick16) begin
               next_r.tx_sub = r.tx_sub + 4'h1;
               bit_end = (r.tx_sub == SU1_OVS_LAST);
            end
            if (bit_end) begin
               next_r.tx_sh = {1'b1, r.tx_sh[10:1]};
               next_r.tx_left = r.tx_left - 4'h1;
               if (r.tx_left == ((mode == SU1_MODE0) ? SU1_M0_END
                                                     : SU1_ASY_END)) begin
                  tx_ev = 1'b1;
               end
               if (r.tx_left == SU1_M0_END) begin
                  next_r.tx_st = SU1_TX_IDLE;
               end
            end
         end
         default: next_r.tx_st = SU1_TX_IDLE;
      endcase

      // Receiver
      case (r.rx_st)
         SU1_RX_IDLE: begin
            if (mode != SU1_MODE0 && r.ctrl[SU1_B_REN] && r.rx_prev
                && !r.rx_s2) begin
               next_r.rx_st = SU1_RX_START;
               next_r.rx_sub = 4'h0;
            end
         end
         SU1_RX_START: begin
            if (tick16) begin
               next_r.rx_sub = r.rx_sub + 4'h1;
               if (r.rx_sub == SU1_OVS_MID) begin
                  if (r.rx_s2) begin
                     next_r.rx_st = SU1_RX_IDLE;
                  end else begin
                     next_r.rx_st = SU1_RX_DATA;
                     next_r.rx_left = SU1_RX_BITS;
                  end
               end
            end
         end
         SU1_RX_DATA: begin
            if (tick16) begin
               next_r.rx_sub = r.rx_sub + 4'h1;
               if (r.rx_sub == SU1_OVS_MID) begin
                  rx_new = {r.rx_s2, r.rx_sh[8:1]};
                  next_r.rx_sh = rx_new;
                  next_r.rx_left = r.rx_left - 4'h1;
                  if (r.rx_left == SU1_M0_END) begin
                     rx_fin = 1'b1;
                     next_r.rx_st = SU1_RX_IDLE;
                  end
               end
            end
         end
         SU1_RX_SYNC: begin
            if (m0_half) begin
               next_r.rx_ph = !r.rx_ph;
               if (!r.rx_ph) begin
                  next_r.rx_sh = {r.rx_s2, r.rx_sh[8:1]};
               end else begin
                  next_r.rx_left = r.rx_left - 4'h1;
                  if (r.rx_left == SU1_M0_END) begin
                     rx_fin = 1'b1;
                     next_r.rx_st = SU1_RX_IDLE;
                  end
               end
            end
         end
         default: next_r.rx_st = SU1_RX_IDLE;
      endcase
      if (mode != SU1_MODE0 && !r.ctrl[SU1_B_REN]) begin
         next_r.rx_st = SU1_RX_IDLE;
      end
      if (m0_rx_go && r.tx_st == SU1_TX_IDLE
          && r.rx_st == SU1_RX_IDLE) begin
         next_r.rx_st = SU1_RX_SYNC;
         next_r.rx_left = SU1_M0_BITS;
         next_r.rx_ph = 1'b0;
      end

      // A full receive buffer drops the new byte
      if (rx_fin && !r.ctrl[SU1_B_RI]) begin
         if (mode == SU1_MODE0) begin
            next_r.rx_buf = rx_new[8:1];
            rx_ev = 1'b1;
         end else if (!r.ctrl[SU1_B_MP] || rx_new[8]) begin
            next_r.rx_buf = rx_new[7:0];
            next_r.ctrl[SU1_B_RB8] = rx_new[8];
            rx_ev = 1'b1;
         end
      end

      // Hardware sets win over a software clear in the same cycle
      if (tx_ev) begin
         next_r.ctrl[SU1_B_TI] = 1'b1;
         next_r.ist[SU1_I_TX] = 1'b1;
      end
      if (rx_ev) begin
         next_r.ctrl[SU1_B_RI] = 1'b1;
         next_r.ist[SU1_I_RX] = 1'b1;
      end

      // Pins and interrupt
      next_r.rx_s1 = rxd_i;
      next_r.rx_s2 = r.rx_s1;
      next_r.rx_prev = r.rx_s2;
      next_r.rxd_oe = (next_r.tx_st == SU1_TX_BUSY) && (mode == SU1_MODE0);
      next_r.rxd_o = next_r.tx_sh[0];
      if (next_r.tx_st == SU1_TX_BUSY) begin
         next_r.txd = (mode == SU1_MODE0) ? next_r.tx_ph : next_r.tx_sh[0];
      end else if (next_r.rx_st == SU1_RX_SYNC) begin
         next_r.txd = next_r.rx_ph;
      end else begin
         next_r.txd = 1'b1;
      end
      next_r.irq = |(next_r.ist & next_r.ien);
      next_r.irq_prio = next_r.cfg[SU1_C_PRIO];
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         r <= '0;
         r.ctrl <= SU1_CTRL_RST;
         r.tx_buf <= SU1_BUF_RST;
         r.rx_buf <= SU1_BUF_RST;
         r.cfg <= SU1_CFG_RST;
         r.t2_rl <= SU1_T2RL_RST;
         r.ien <= SU1_IEN_RST;
         r.rx_s1 <= 1'b1;
         r.rx_s2 <= 1'b1;
         r.rx_prev <= 1'b1;
         r.txd <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign rxd_o = r.rxd_o;
   assign rxd_oe = r.rxd_oe;
   assign txd = r.txd;
   assign irq = r.irq;
   assign irq_prio = r.irq_prio;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_tb8_frame: assert property (
      (tx_start && mode[1]) |=> r.tx_sh[9] == $past(r.ctrl[SU1_B_TB8])
   ) else $error("ninth transmit bit not placed in frame");
   chk_tx_done: assert property (
      tx_ev |=> r.ctrl[SU1_B_TI] && r.ist[SU1_I_TX]
         && (!r.ien[SU1_I_TX] || irq)
   ) else $error("transmit done not flagged");
   chk_rx_done: assert property (
      rx_ev |=> r.ctrl[SU1_B_RI] && r.ist[SU1_I_RX]
   ) else $error("receive done not flagged");
   chk_rb8_load: assert property (
      (rx_ev && mode != SU1_MODE0) |=> r.ctrl[SU1_B_RB8] == $past(rx_new[8])
   ) else $error("ninth received bit not captured");
   chk_mp_gate: assert property (
      (rx_ev && mode != SU1_MODE0 && r.ctrl[SU1_B_MP]) |-> rx_new[8]
   ) else $error("multiproc frame accepted with ninth bit low");
   chk_rx_hold: assert property (
      (rx_fin && r.ctrl[SU1_B_RI]) |=> $stable(r.rx_buf)
   ) else $error("receive buffer overwritten while flag set");
   chk_buf_split: assert property (
      (wr && paddr == su1_addr(SU1_IDX_BUF))
         |=> r.tx_buf == $past(pwdata[7:0]) && $stable(r.rx_buf)
   ) else $error("buffer write reached the receive side");
   chk_ren_gate: assert property (
      (mode != SU1_MODE0 && !r.ctrl[SU1_B_REN] && !m0_rx_go)
         |=> r.rx_st == SU1_RX_IDLE
   ) else $error("reception ran without enable");
   chk_line_idle: assert property (
      (r.tx_st == SU1_TX_IDLE && r.rx_st == SU1_RX_IDLE) |-> txd
   ) else $error("line not high while idle");
   chk_start_low: assert property (
      (tx_start && mode != SU1_MODE0) |=> !txd [*2]
   ) else $error("frame did not open with low start bit");

   cov_async_tx: cover property (tx_ev && mode == SU1_MODE1);
   cov_async_rx: cover property (rx_ev && mode == SU1_MODE2);
   cov_sync_rx: cover property (rx_ev && mode == SU1_MODE0);
   cov_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ==== tb/su1_peer.sv ====
/*
 Remote serial device: sends frames on rxd, captures frames from txd.
 Assumes one clock domain and a bit time given in clocks.
*/
`default_nettype none
module su1_peer (
   input  wire logic       clk_sys, // System clock
   input  wire logic [6:0] per,     // Clocks per bit
   input  wire logic       txd,     // Device transmit line
   output logic            rxd,     // Line into the device
   output logic [10:0]     got,     // Last frame seen
   output logic [7:0]      n_seen   // Frames seen
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rxd = 1'b1;
      n_seen = 8'h00;
   end
   // =====
   // Sender
   task automatic send(input logic [8:0] d);
      logic [10:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (per) @(posedge clk_sys);
      end
   endtask
   // =====
   // Monitor, mid-bit sampling
   always begin
      @(negedge txd);
      repeat (per / 2) @(posedge clk_sys);
      for (int i = 0; i < 11; i++) begin
         got[i] = txd;
         repeat (per) @(posedge clk_sys);
      end
      n_seen = n_seen + 8'h01;
   end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/*
 Bench for serial port one: APB access, mode 2 frames both ways,
 multiprocessor filtering, interrupt status and priority.
 Assumes su1_peer on the line; idle held low, timer 1 overflow pulsed every 4 clocks.
*/
`default_nettype none
module tb import su1_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        rxd_o, rxd_oe, txd, irq, irq_prio, peer_rxd, err;
   logic [6:0]  per;
   logic [10:0] got;
   logic [7:0]  n_seen;
   logic [1:0]  t1_cnt;
   logic        t1_ovf;
   int          n_fail, n_compared;
   wire logic   rxd_line = rxd_oe ? rxd_o : peer_rxd;

   su1_uart su1_uart_i (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle(1'b0),
      .timer1_ovf(t1_ovf), .rxd_i(rxd_line), .rxd_o(rxd_o),
      .rxd_oe(rxd_oe), .txd(txd), .irq(irq), .irq_prio(irq_prio));
   su1_peer peer_i (.clk_sys(clk_sys), .per(per), .txd(txd),
      .rxd(peer_rxd), .got(got), .n_seen(n_seen));

   // =====
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ix,
                      input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= su1_addr(ix);
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rdc(input logic [7:0] ix, input logic [31:0] e,
                      input string nm);
      apb(1'b0, ix, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic wait_frame();
      logic [7:0] n0;
      n0 = n_seen;
      for (int t = 0; t < 3000 && n_seen === n0; t++) @(posedge clk_sys);
   endtask
   task automatic final_report();
      if (n_fail == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // =====
   // Clock, watchdog, tests
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Timer 1 overflow every 4 clocks: 64 clocks per async bit
   always @(posedge clk_sys) begin
      t1_cnt <= t1_cnt + 2'h1;
      t1_ovf <= (t1_cnt == 2'h3);
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      final_report();
   end
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      per = 7'h40;
      t1_cnt = 2'h0;
      t1_ovf = 1'b0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      rdc(SU1_IDX_CTRL, 32'h0, "ctrl_rst");
      rdc(SU1_IDX_BUF, 32'h0, "buf_rst");
      rdc(8'hD0, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, err});
      apb(1'b1, SU1_IDX_CFG, 32'h2);
      chk("prio", 32'h1, {31'h0, irq_prio});
      for (int d = 0; d < 2; d++) begin
         per <= d ? 7'h20 : 7'h40;
         apb(1'b1, SU1_IDX_CFG, 32'(d));
         apb(1'b1, SU1_IDX_CTRL, d ? 32'h80 : 32'h88);
         apb(1'b1, SU1_IDX_BUF, 32'hA5);
         wait_frame();
         chk("frame", {21'h0, 1'b1, ~d[0], 8'hA5, 1'b0},
             {21'h0, got});
         rdc(SU1_IDX_CTRL, d ? 32'h82 : 32'h8A, "tx_done");
      end
      per <= 7'h40;
      apb(1'b1, SU1_IDX_CFG, 32'h0);
      apb(1'b1, SU1_IDX_CTRL, 32'h40);
      apb(1'b1, SU1_IDX_BUF, 32'h5A);
      wait_frame();
      chk("frame_m1", {21'h0, 2'h3, 8'h5A, 1'b0}, {21'h0, got});
      rdc(SU1_IDX_CTRL, 32'h42, "tx_done_m1");
      apb(1'b1, SU1_IDX_CTRL, 32'h50);
      peer_i.send(9'h1C3);
      rdc(SU1_IDX_BUF, 32'hC3, "rx_buf_m1");
      rdc(SU1_IDX_CTRL, 32'h55, "stop_bit_m1");
      apb(1'b1, SU1_IDX_IEN, 32'h2);
      apb(1'b1, SU1_IDX_CTRL, 32'h90);
      peer_i.send(9'h13C);
      chk("irq_set", 32'h1, {31'h0, irq});
      rdc(SU1_IDX_BUF, 32'h3C, "rx_buf");
      rdc(SU1_IDX_CTRL, 32'h95, "rx_done");
      rdc(SU1_IDX_IST, 32'h3, "ist");
      apb(1'b1, SU1_IDX_ICLR, 32'h2);
      chk("irq_clr", 32'h0, {31'h0, irq});
      apb(1'b1, SU1_IDX_CTRL, 32'hB0);
      peer_i.send(9'h055);
      rdc(SU1_IDX_CTRL, 32'hB0, "mp_drop");
      peer_i.send(9'h1AA);
      rdc(SU1_IDX_BUF, 32'hAA, "mp_keep");
      rdc(SU1_IDX_CTRL, 32'hB5, "mp_flag");
      final_report();
   end
endmodule
`default_nettype wire
